// file: hw/fid_pkg.sv
// Package: offsets, field layout, fixed field values and states of the ID bank
package fid_pkg;

  typedef logic [3:0]  fid_nib_t;
  typedef logic [31:0] fid_word_t;

  localparam int unsigned FID_ADDR_W = 4;
  localparam int unsigned FID_IDX_W  = 2;
  localparam int unsigned FID_NREGS  = 3;

  // Byte offsets inside the block, one aligned word each
  localparam logic [3:0] FID_OFF_ISA4 = 4'h0;
  localparam logic [3:0] FID_OFF_FP0  = 4'h4;
  localparam logic [3:0] FID_OFF_FP1  = 4'h8;

  localparam logic [1:0] FID_IDX_ISA4 = 2'h0;
  localparam logic [1:0] FID_IDX_FP0  = 2'h1;
  localparam logic [1:0] FID_IDX_FP1  = 2'h2;

  // instruction_set_attributes_4 field positions
  localparam int unsigned FID_ISA4_STATUS_LSB = 24;
  localparam int unsigned FID_ISA4_SYNCF_LSB  = 20;
  localparam int unsigned FID_ISA4_BARR_LSB   = 16;
  localparam int unsigned FID_ISA4_WB_LSB     = 8;
  localparam int unsigned FID_ISA4_SHIFT_LSB  = 4;
  localparam int unsigned FID_ISA4_UNPRIV_LSB = 0;

  // fp_feature_0 field positions
  localparam int unsigned FID_FP0_ROUND_LSB = 28;
  localparam int unsigned FID_FP0_SVEC_LSB  = 24;
  localparam int unsigned FID_FP0_SQRT_LSB  = 20;
  localparam int unsigned FID_FP0_DIV_LSB   = 16;
  localparam int unsigned FID_FP0_TRAP_LSB  = 12;
  localparam int unsigned FID_FP0_DP_LSB    = 8;
  localparam int unsigned FID_FP0_SP_LSB    = 4;
  localparam int unsigned FID_FP0_BANK_LSB  = 0;

  // fp_feature_1 field positions
  localparam int unsigned FID_FP1_FMAC_LSB   = 28;
  localparam int unsigned FID_FP1_HALF_LSB   = 24;
  localparam int unsigned FID_FP1_NAN_LSB    = 4;
  localparam int unsigned FID_FP1_DENORM_LSB = 0;

  // Fixed field values
  localparam fid_nib_t FID_V_ZERO    = 4'h0;
  localparam fid_nib_t FID_V_ONE     = 4'h1;
  localparam fid_nib_t FID_V_TWO     = 4'h2;
  localparam fid_nib_t FID_V_THREE   = 4'h3;
  localparam fid_nib_t FID_V_STATUS  = 4'h1;
  localparam fid_nib_t FID_V_BARRIER = 4'h1;
  localparam fid_nib_t FID_V_WB_FULL = 4'h1;
  localparam fid_nib_t FID_V_ROUND   = 4'h1;
  localparam fid_nib_t FID_V_SVEC    = 4'h0;
  localparam fid_nib_t FID_V_SQRT    = 4'h1;
  localparam fid_nib_t FID_V_DIV     = 4'h1;
  localparam fid_nib_t FID_V_TRAP    = 4'h0;
  localparam fid_nib_t FID_V_DP_NONE = 4'h0;
  localparam fid_nib_t FID_V_DP_HW   = 4'h2;
  localparam fid_nib_t FID_V_SP      = 4'h2;
  localparam fid_nib_t FID_V_BANK    = 4'h1;
  localparam fid_nib_t FID_V_FMAC    = 4'h1;
  localparam fid_nib_t FID_V_NAN     = 4'h1;
  localparam fid_nib_t FID_V_DENORM  = 4'h1;

  localparam fid_word_t FID_WORD_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    FID_ST_IDLE = 3'b001,
    FID_ST_READ = 3'b010,
    FID_ST_WRIT = 3'b100
  } fid_state_t;

endpackage : fid_pkg

// file: hw/fid_word_if.sv
// Interface: field values in, packed identification words out
`timescale 1ns/100ps
`default_nettype none
interface fid_word_if;
  import fid_pkg::*;
  fid_nib_t  syncFrac;
  fid_nib_t  shiftOpt;
  fid_nib_t  unprivLvl;
  fid_nib_t  dpField;
  fid_nib_t  halfConv;
  fid_word_t isaWord;
  fid_word_t fp0Word;
  fid_word_t fp1Word;
  modport cfg (output syncFrac, shiftOpt, unprivLvl, dpField, halfConv,
               input isaWord, fp0Word, fp1Word);
  modport isa (input syncFrac, shiftOpt, unprivLvl, output isaWord);
  modport fp  (input dpField, halfConv, output fp0Word, fp1Word);
endinterface : fid_word_if
`default_nettype wire

// file: hw/fid_isa_pack.sv
// Packs instruction_set_attributes_4 from its field values
`timescale 1ns/100ps
`default_nettype none
module fid_isa_pack (
  fid_word_if.isa w
);
  import fid_pkg::*;
  fid_word_t word;
  always_comb begin
    // Reserved nibbles stay zero
    word = FID_WORD_RST;
    word[FID_ISA4_STATUS_LSB +: 4] = FID_V_STATUS;
    word[FID_ISA4_SYNCF_LSB +: 4]  = w.syncFrac;
    word[FID_ISA4_BARR_LSB +: 4]   = FID_V_BARRIER;
    word[FID_ISA4_WB_LSB +: 4]     = FID_V_WB_FULL;
    word[FID_ISA4_SHIFT_LSB +: 4]  = w.shiftOpt;
    word[FID_ISA4_UNPRIV_LSB +: 4] = w.unprivLvl;
  end
  assign w.isaWord = word;
endmodule : fid_isa_pack
`default_nettype wire

// file: hw/fid_fp_pack.sv
// Packs fp_feature_0 and fp_feature_1 from their field values
`timescale 1ns/100ps
`default_nettype none
module fid_fp_pack (
  fid_word_if.fp w
);
  import fid_pkg::*;
  fid_word_t w0;
  fid_word_t w1;
  always_comb begin
    w0 = FID_WORD_RST;
    w0[FID_FP0_ROUND_LSB +: 4] = FID_V_ROUND;
    w0[FID_FP0_SVEC_LSB +: 4]  = FID_V_SVEC;
    w0[FID_FP0_SQRT_LSB +: 4]  = FID_V_SQRT;
    w0[FID_FP0_DIV_LSB +: 4]   = FID_V_DIV;
    w0[FID_FP0_TRAP_LSB +: 4]  = FID_V_TRAP;
    w0[FID_FP0_DP_LSB +: 4]    = w.dpField;
    w0[FID_FP0_SP_LSB +: 4]    = FID_V_SP;
    w0[FID_FP0_BANK_LSB +: 4]  = FID_V_BANK;
    // Bits 23..8 never written here, so they read zero
    w1 = FID_WORD_RST;
    w1[FID_FP1_FMAC_LSB +: 4]   = FID_V_FMAC;
    w1[FID_FP1_HALF_LSB +: 4]   = w.halfConv;
    w1[FID_FP1_NAN_LSB +: 4]    = FID_V_NAN;
    w1[FID_FP1_DENORM_LSB +: 4] = FID_V_DENORM;
  end
  assign w.fp0Word = w0;
  assign w.fp1Word = w1;
endmodule : fid_fp_pack
`default_nettype wire

// file: hw/fid_feature_regs.sv
// Top: read-only instruction set and FP feature identification bank
//
// Functional notes
// - Status access field fixed at one
// - Sync fraction nibble, decoded with level
// - Barrier field fixed at one
// - Writeback field reports full support
// - Shift option only 0, 1 or 3
// - Unprivileged variants level one or two
// - Sync pairs (0,0), (1,0), (1,3) only
// - Never report any other sync pair
// - FP registers exist only with FP built
// - Rounding modes field reads one
// - Short vector field reads zero
// - Square root field reads one
// - Divide field reads one
// - Exception trapping field reads zero
// - Double field zero or two by build
// - Single field reads two
// - Register bank field reads one
// - fp_feature_1 bits 23..8 read zero
// - Fused multiply-accumulate field reads one
// - Half conversion field one or two
// - NaN propagation field reads one
// - Denormal support field reads one
`timescale 1ns/100ps
`default_nettype none
module fid_feature_regs #(
  parameter bit          FP_PRESENT   = 1'b1,
  parameter bit          DP_PRESENT   = 1'b0,
  parameter logic [3:0]  HALF_CONV    = 4'h1,
  parameter logic [3:0]  SYNC_LEVEL   = 4'h1,
  parameter logic [3:0]  SYNC_FRAC    = 4'h3,
  parameter logic [3:0]  SHIFT_OPT    = 4'h3,
  parameter logic [3:0]  UNPRIV_LEVEL = 4'h2
) (
  // Clock and reset
  input  wire  logic                            core_clk,
  input  wire  logic                            reset,
  // Register access from the system control space
  input  wire  logic                            busReq,
  input  wire  logic                            busWrite,
  input  wire  logic [fid_pkg::FID_ADDR_W-1:0] busAddr,
  output logic                                  busReady,
  output logic                                  busError,
  output logic [31:0]                           busReadData,
  // Build status
  output logic                                  fpPresent,
  output logic [3:0]                            syncPrimitiveLevel,
  output logic                                  configClamped
);
  import fid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Legality of build options

  function automatic bit fid_sync_legal(input fid_nib_t lvl,
                                        input fid_nib_t frac);
    bit ok;
    ok = 1'b0;
    if ((lvl == FID_V_ZERO) && (frac == FID_V_ZERO)) begin
      ok = 1'b1;
    end
    if ((lvl == FID_V_ONE) && (frac == FID_V_ZERO)) begin
      ok = 1'b1;
    end
    if ((lvl == FID_V_ONE) && (frac == FID_V_THREE)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : fid_sync_legal

  function automatic bit fid_shift_legal(input fid_nib_t v);
    return (v == FID_V_ZERO) || (v == FID_V_ONE) || (v == FID_V_THREE);
  endfunction : fid_shift_legal

  function automatic bit fid_unpriv_legal(input fid_nib_t v);
    return (v == FID_V_ONE) || (v == FID_V_TWO);
  endfunction : fid_unpriv_legal

  function automatic bit fid_half_legal(input fid_nib_t v, input bit dp);
    // Half to double conversion makes no sense without double hardware
    return (v == FID_V_ONE) || ((v == FID_V_TWO) && dp);
  endfunction : fid_half_legal

  // Illegal options fall back to the weakest legal report, never to a
  // reserved code; the clamp is visible on configClamped
  localparam bit SYNC_OK   = fid_sync_legal(SYNC_LEVEL, SYNC_FRAC);
  localparam bit SHIFT_OK  = fid_shift_legal(SHIFT_OPT);
  localparam bit UNPRIV_OK = fid_unpriv_legal(UNPRIV_LEVEL);
  localparam bit HALF_OK   = fid_half_legal(HALF_CONV, DP_PRESENT);

  localparam fid_nib_t SYNC_LEVEL_EFF =
    SYNC_OK ? SYNC_LEVEL : FID_V_ZERO;
  localparam fid_nib_t SYNC_FRAC_EFF =
    SYNC_OK ? SYNC_FRAC : FID_V_ZERO;
  localparam fid_nib_t SHIFT_EFF =
    SHIFT_OK ? SHIFT_OPT : FID_V_ZERO;
  localparam fid_nib_t UNPRIV_EFF =
    UNPRIV_OK ? UNPRIV_LEVEL : FID_V_ONE;
  localparam fid_nib_t HALF_EFF =
    HALF_OK ? HALF_CONV : FID_V_ONE;
  localparam fid_nib_t DP_EFF =
    DP_PRESENT ? FID_V_DP_HW : FID_V_DP_NONE;
  localparam bit CLAMPED =
    !(SYNC_OK && SHIFT_OK && UNPRIV_OK && HALF_OK);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by reads and writes

  function automatic bit fid_addr_hit(input logic [FID_ADDR_W-1:0] a,
                                      input bit fpOn);
    bit hit;
    hit = 1'b0;
    if (a == FID_OFF_ISA4) begin
      hit = 1'b1;
    end
    // FP words are absent, not merely zero, without the extension
    if (((a == FID_OFF_FP0) || (a == FID_OFF_FP1)) && fpOn) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : fid_addr_hit

  function automatic logic [FID_IDX_W-1:0] fid_addr_idx(
    input logic [FID_ADDR_W-1:0] a);
    logic [FID_IDX_W-1:0] idx;
    idx = FID_IDX_ISA4;
    if (a == FID_OFF_FP0) begin
      idx = FID_IDX_FP0;
    end
    if (a == FID_OFF_FP1) begin
      idx = FID_IDX_FP1;
    end
    return idx;
  endfunction : fid_addr_idx

  ////////////////////////////////////////////////////////////////////////////
  // Word packing

  fid_word_if words ();

  assign words.syncFrac  = SYNC_FRAC_EFF;
  assign words.shiftOpt  = SHIFT_EFF;
  assign words.unprivLvl = UNPRIV_EFF;
  assign words.dpField   = DP_EFF;
  assign words.halfConv  = HALF_EFF;

  fid_isa_pack uIsa (
    .w (words.isa)
  );

  fid_fp_pack uFp (
    .w (words.fp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Identification storage

  fid_word_t idWord [FID_NREGS];
  fid_word_t idStore_r [FID_NREGS];

  assign idWord[0] = words.isaWord;
  assign idWord[1] = FP_PRESENT ? words.fp0Word : FID_WORD_RST;
  assign idWord[2] = FP_PRESENT ? words.fp1Word : FID_WORD_RST;

  // Loaded in reset only; the bus has no write path into it
  for (genvar g = 0; g < FID_NREGS; g++) begin : gStore
    always_ff @(posedge core_clk) begin
      if (reset) begin
        idStore_r[g] <= idWord[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Build status

  logic fpPresent_r;
  logic [3:0] syncLevel_r;
  logic configClamped_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fpPresent_r     <= FP_PRESENT;
      syncLevel_r     <= SYNC_LEVEL_EFF;
      configClamped_r <= CLAMPED;
    end
  end

  assign fpPresent          = fpPresent_r;
  assign syncPrimitiveLevel = syncLevel_r;
  assign configClamped      = configClamped_r;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing

  fid_state_t state_r;
  fid_state_t state_nxt;

  logic                 accept;
  logic                 reqHit;
  logic [FID_IDX_W-1:0] reqIdx;
  fid_word_t            readData_r;
  fid_word_t            readData_nxt;
  logic                 error_r;
  logic                 error_nxt;

  // Requests are taken only in idle; a request held during the answer
  // cycle is seen again afterwards, so hold it low once answered
  assign accept = busReq && (state_r == FID_ST_IDLE);
  assign reqHit = fid_addr_hit(busAddr, FP_PRESENT);
  assign reqIdx = fid_addr_idx(busAddr);

  always_comb begin
    state_nxt = FID_ST_IDLE;
    unique case (state_r)
      FID_ST_IDLE: begin
        if (accept) begin
          state_nxt = busWrite ? FID_ST_WRIT : FID_ST_READ;
        end
      end
      FID_ST_READ: begin
        state_nxt = FID_ST_IDLE;
      end
      FID_ST_WRIT: begin
        state_nxt = FID_ST_IDLE;
      end
      default: begin
        state_nxt = FID_ST_IDLE;
      end
    endcase
  end

  // Writes to a mapped word answer cleanly and change nothing
  assign readData_nxt =
    (accept && !busWrite && reqHit) ? idStore_r[reqIdx] :
    FID_WORD_RST;
  assign error_nxt = accept && !reqHit;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r    <= FID_ST_IDLE;
      readData_r <= FID_WORD_RST;
      error_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      readData_r <= readData_nxt;
      error_r    <= error_nxt;
    end
  end

  assign busReady    = (state_r != FID_ST_IDLE);
  assign busError    = error_r;
  assign busReadData = readData_r;

endmodule : fid_feature_regs
`default_nettype wire

// file: tb/fid_feature_regs_assertions.sv
// Checker: bus answer timing and identification word contents
`timescale 1ns/100ps
`default_nettype none
module fid_feature_regs_assertions #(
  parameter bit FP_PRESENT = 1'b1,
  parameter bit DP_PRESENT = 1'b0
) (
  // Clock and reset
  input wire logic                           core_clk,
  input wire logic                           reset,
  // Register access
  input wire logic                           busReq,
  input wire logic                           busWrite,
  input wire logic [fid_pkg::FID_ADDR_W-1:0] busAddr,
  input wire logic                           busReady,
  input wire logic                           busError,
  input wire logic [31:0]                    busReadData,
  // Build status
  input wire logic                           fpPresent,
  input wire logic [3:0]                     syncPrimitiveLevel,
  input wire logic                           configClamped
);
  import fid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Request seen one cycle before the answer
  logic [3:0] addrSeen_r;
  logic       writeSeen_r;
  always_ff @(posedge core_clk) begin
    addrSeen_r  <= busAddr;
    writeSeen_r <= busWrite;
  end
  wire logic rdIsa  = busReady && !writeSeen_r && addrSeen_r == FID_OFF_ISA4;
  wire logic atFp0  = busReady && addrSeen_r == FID_OFF_FP0;
  wire logic atFp1  = busReady && addrSeen_r == FID_OFF_FP1;
  wire logic mapped = addrSeen_r == FID_OFF_ISA4 || addrSeen_r == FID_OFF_FP0
                      || addrSeen_r == FID_OFF_FP1;
  wire logic [31:0] fp0Exp = DP_PRESENT ? 32'h1011_0221 : 32'h1011_0021;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_take; busReq && !busReady |=> busReady; endproperty
  a_take: assert property (p_take)
    else $error("request not answered next cycle");
  property p_pulse; busReady |=> !busReady && busReadData == 32'h0; endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer held longer than one cycle");
  property p_quiet;
    !busReady |-> !busError && busReadData == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer outputs active outside answer");
  property p_isa_fixed;
    rdIsa |-> busReadData[31:24] == 8'h01 && busReadData[19:8] == 12'h101;
  endproperty
  a_isa_fixed: assert property (p_isa_fixed)
    else $error("fixed attribute fields wrong");
  property p_sync;
    rdIsa |-> {syncPrimitiveLevel, busReadData[23:20]} inside
      {8'h00, 8'h10, 8'h13};
  endproperty
  a_sync: assert property (p_sync)
    else $error("reserved sync pair reported");
  property p_shift;
    rdIsa |-> busReadData[7:4] inside {4'h0, 4'h1, 4'h3} &&
      busReadData[3:0] inside {4'h1, 4'h2};
  endproperty
  a_shift: assert property (p_shift)
    else $error("reserved shift or unprivileged value");
  property p_fp0;
    atFp0 && FP_PRESENT && !writeSeen_r |-> busReadData == fp0Exp;
  endproperty
  a_fp0: assert property (p_fp0)
    else $error("fp_feature_0 wrong");
  property p_fp1;
    atFp1 && FP_PRESENT && !writeSeen_r |-> busReadData[23:0] == 24'h000011
      && busReadData[31:28] == 4'h1 && (busReadData[27:24] == 4'h1 ||
      (DP_PRESENT && busReadData[27:24] == 4'h2));
  endproperty
  a_fp1: assert property (p_fp1)
    else $error("fp_feature_1 wrong");
  property p_fp_gate; atFp0 || atFp1 |-> busError == !FP_PRESENT; endproperty
  a_fp_gate: assert property (p_fp_gate)
    else $error("fp word presence wrong");
  property p_bad; busReady && !mapped |-> busError; endproperty
  a_bad: assert property (p_bad)
    else $error("unmapped offset not refused");
  property p_flag; fpPresent == FP_PRESENT; endproperty
  a_flag: assert property (p_flag)
    else $error("fp build flag wrong");

  c_isa: cover property (rdIsa);
  c_err: cover property (busReady && busError);
  c_wr:  cover property (busReady && writeSeen_r);
endmodule : fid_feature_regs_assertions

bind fid_feature_regs fid_feature_regs_assertions #(
  .FP_PRESENT(FP_PRESENT), .DP_PRESENT(DP_PRESENT)
) u_chk (
  .core_clk(core_clk), .reset(reset), .busReq(busReq),
  .busWrite(busWrite), .busAddr(busAddr), .busReady(busReady),
  .busError(busError), .busReadData(busReadData), .fpPresent(fpPresent),
  .syncPrimitiveLevel(syncPrimitiveLevel), .configClamped(configClamped)
);
`default_nettype wire

// file: tb/tb.sv
// Testbench: reads, writes and refusals on three builds of the ID bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fid_pkg::*;
  // Build 0 asks half-double without double; build 1 has both;
  // build 2: no FP, illegal sync, shift and unprivileged level
  localparam bit         FPP[3] = '{1'b1, 1'b1, 1'b0};
  localparam bit         DPP[3] = '{1'b0, 1'b1, 1'b0};
  localparam logic [3:0] HLF[3] = '{4'h2, 4'h2, 4'h1};
  localparam logic [3:0] SLV[3] = '{4'h1, 4'h1, 4'h2};
  localparam logic [3:0] SFR[3] = '{4'h3, 4'h0, 4'h0};
  localparam logic [3:0] SHF[3] = '{4'h3, 4'h1, 4'h4};
  localparam logic [3:0] UPV[3] = '{4'h2, 4'h1, 4'h0};

  logic        core_clk;
  logic        reset;
  logic        busReq;
  logic        busWrite;
  logic [3:0]  busAddr;
  logic        rdy[3];
  logic        err[3];
  logic [31:0] rdData[3];
  logic        fpOn[3];
  logic [3:0]  syncLvl[3];
  logic        clamped[3];
  logic        gotE[3];
  logic [31:0] gotD[3];
  logic [31:0] expD;
  logic        expE;
  int          fail_count;
  int          comparisons;

  fid_word_t isaExp[3] = '{32'h0131_0132, 32'h0101_0111, 32'h0101_0101};
  fid_word_t fp0Exp[3] = '{32'h1011_0021, 32'h1011_0221, 32'h0000_0000};
  fid_word_t fp1Exp[3] = '{32'h1100_0011, 32'h1200_0011, 32'h0000_0000};
  logic [3:0] lvlExp[3] = '{4'h1, 4'h1, 4'h0};

  for (genvar g = 0; g < 3; g++) begin : g_dut
    fid_feature_regs #(
      .FP_PRESENT(FPP[g]), .DP_PRESENT(DPP[g]), .HALF_CONV(HLF[g]),
      .SYNC_LEVEL(SLV[g]), .SYNC_FRAC(SFR[g]), .SHIFT_OPT(SHF[g]),
      .UNPRIV_LEVEL(UPV[g])
    ) DUT (
      .core_clk(core_clk), .reset(reset), .busReq(busReq),
      .busWrite(busWrite), .busAddr(busAddr), .busReady(rdy[g]),
      .busError(err[g]), .busReadData(rdData[g]), .fpPresent(fpOn[g]),
      .syncPrimitiveLevel(syncLvl[g]), .configClamped(clamped[g])
    );
  end

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  // Request held until the answer is seen, then one idle cycle follows
  task automatic access(input logic wr, input logic [3:0] addr);
    int n;
    @(posedge core_clk);
    #1;
    busReq   = 1'b1;
    busWrite = wr;
    busAddr  = addr;
    for (n = 0; n < 4 && rdy[0] !== 1'b1; n++) @(negedge core_clk);
    if (rdy[0] !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: no answer", $time);
      close_out();
    end
    gotD = rdData;
    gotE = err;
    @(posedge core_clk);
    #1;
    busReq = 1'b0;
  endtask : access

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset       = 1'b1;
    busReq      = 1'b0;
    busWrite    = 1'b0;
    busAddr     = 4'h0;
    fail_count  = 0;
    comparisons = 0;
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    for (int d = 0; d < 3; d++) begin
      chk_flag(rdy[d], 1'b0);
      chk_word(rdData[d], 32'h0000_0000);
      chk_flag(fpOn[d], FPP[d]);
      chk_word({28'h0000000, syncLvl[d]}, {28'h0000000, lvlExp[d]});
      chk_flag(clamped[d], d != 1);
    end
    // Read every offset, write every offset, then read all again
    for (int p = 0; p < 3; p++) begin
      for (int a = 0; a < 16; a++) begin
        access(p == 1, a[3:0]);
        for (int d = 0; d < 3; d++) begin
          expD = a == 0 ? isaExp[d] : a == 4 ? fp0Exp[d] :
                 a == 8 ? fp1Exp[d] : 32'h0000_0000;
          if (p == 1)
            expD = 32'h0000_0000;
          expE = !(a == 0 || (FPP[d] && (a == 4 || a == 8)));
          chk_flag(gotE[d], expE);
          chk_word(gotD[d], expD);
        end
      end
    end
    close_out();
  end
endmodule : tb
`default_nettype wire
